//--- hdl/atr_top.sv
// Operation
// - mic amps powered only while enabled
// - right input: mic pin or line
// - left input: mic pin or line
// - voice mode sends left source both, right source if left amp off
// - stereo keeps left and right separate
// - voice duplicates, no left digital mic
// - two-bit pre-gain code to dB table
// - input mute silences the amplifier
// - one converter gain for both channels
// - tx volume linear, default zero dB
// - digital mic volume coding inverted
// - pdm stream goes straight to filter
// - dmic clock gated, 1 or 2 MHz
// - right pin switchable to digital mic
// - sidetone adds dmic into voice dac
// - separate mutes for port and dac
// - source selects: dmic or converter
// - two dmics need stereo, left/right
// - voice enable wins over stereo enable
`timescale 1ns/10ps
`default_nettype none
module atr_top
   import atr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end controls
   output logic left_amp_power,
   output logic right_amp_power,
   output logic left_src_is_line,
   output logic right_src_is_line,
   output logic left_amp_mute,
   output logic right_amp_mute,
   output logic signed [7:0] left_pre_db,
   output logic signed [7:0] right_pre_db,
   output logic [4:0] conv_gain,
   output logic signed [7:0] left_vol_db,
   output logic signed [7:0] right_vol_db,
   output logic signed [7:0] dmic_vol_db,
   output logic signed [7:0] sidetone_db,
   output logic right_pin_digital,
   // digital microphone pins
   output logic dmic_clock_out,
   input wire logic left_mic_pin_data,
   input wire logic right_mic_pin_data,
   // pdm to converter filter
   output logic [1:0] filt_pdm,
   output logic [1:0] filt_pdm_valid,
   // samples from converter and filter
   input wire logic smp_valid,
   input wire logic [15:0] adc_left,
   input wire logic [15:0] adc_right,
   input wire logic [15:0] dmic_first,
   input wire logic [15:0] dmic_second,
   // serial port and sidetone samples
   output logic tx_valid,
   output logic [15:0] voice_left,
   output logic [15:0] voice_right,
   output logic [15:0] stereo_left,
   output logic [15:0] stereo_right,
   output logic [15:0] sidetone
);
   // ****************
   // registers over apb
   // ****************
   logic [CTRL_W-1:0] ctrl_q;
   logic [8:0] gain_q;
   logic [5:0] lvol_q, rvol_q, dvol_q, stg_q;
   logic [31:0] prdata_q;
   logic wr_en, mapped;
   atr_mode_type mode;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ATR_CTRL_OFS) || (a == ATR_GAIN_OFS) ||
         (a == ATR_VOL_OFS) || (a == ATR_STAT_OFS);
   endfunction

   assign mapped = is_mapped(paddr);
   assign wr_en = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
         gain_q <= GAIN_RST;
         lvol_q <= TXVOL_RST;
         rvol_q <= TXVOL_RST;
         dvol_q <= DVOL_RST;
         stg_q <= STG_RST;
      end else if (wr_en) begin
         if (paddr == ATR_CTRL_OFS) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
         end
         if (paddr == ATR_GAIN_OFS) begin
            gain_q <= pwdata[8:0];
         end
         if (paddr == ATR_VOL_OFS) begin
            lvol_q <= pwdata[LVOL_POS +: 6];
            rvol_q <= pwdata[RVOL_POS +: 6];
            dvol_q <= pwdata[DVOL_POS +: 6];
            stg_q <= pwdata[STG_POS +: 6];
         end
      end
   end

   // read data caught in the setup cycle so the access phase needs no wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ATR_CTRL_OFS: prdata_q <= {15'h0000, ctrl_q};
            ATR_GAIN_OFS: prdata_q <= {23'h000000, gain_q};
            ATR_VOL_OFS: prdata_q <= {2'h0, stg_q, 2'h0, dvol_q, 2'h0, rvol_q, 2'h0, lvol_q};
            ATR_STAT_OFS: prdata_q <= {28'h0000000, dmic_clock_out, right_pin_digital, mode};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   // ****************
   // analog front end
   // ****************
   function automatic logic signed [7:0] pre_db(input logic [1:0] c, input logic line);
      unique case (c)
         2'b00: pre_db = 8'sh00;
         2'b01: pre_db = line ? 8'sh08 : 8'sh0C;
         2'b10: pre_db = line ? 8'sh12 : 8'sh14;
         default: pre_db = line ? 8'sh1A : 8'sh1C;
      endcase
   endfunction

   // linear: one dB per step from the bottom code
   function automatic logic signed [7:0] vol_db(input logic [5:0] c);
      vol_db = VOL_MIN_DB + $signed({2'b00, c});
   endfunction

   assign left_amp_power = ctrl_q[LMIC_EN_POS];
   assign right_amp_power = ctrl_q[RMIC_EN_POS];
   assign left_src_is_line = ctrl_q[LSEL_POS];
   assign right_src_is_line = ctrl_q[RSEL_POS];
   assign left_amp_mute = ctrl_q[LMUTE_POS];
   assign right_amp_mute = ctrl_q[RMUTE_POS];
   assign left_pre_db = pre_db(gain_q[LPRE_POS +: 2], ctrl_q[LSEL_POS]);
   assign right_pre_db = pre_db(gain_q[RPRE_POS +: 2], ctrl_q[RSEL_POS]);
   assign conv_gain = gain_q[CGAIN_POS +: 5];
   assign left_vol_db = vol_db(lvol_q);
   assign right_vol_db = vol_db(rvol_q);
   assign dmic_vol_db = DVOL_ZERO_DB_OFS - $signed({2'b00, dvol_q});
   assign sidetone_db = vol_db(stg_q);
   assign right_pin_digital = ctrl_q[RDIG_POS];

   // voice wins when both converter enables are set
   always_comb begin
      if (ctrl_q[VCE_EN_POS]) begin
         mode = ATR_MODE_VOICE;
      end else begin
         mode = ATR_MODE_STEREO;
      end
   end

   // ****************
   // digital mic clock
   // ****************
   logic [5:0] dcnt_q;
   logic [5:0] half;
   logic dclk_q;
   logic half_tick;

   assign half = ctrl_q[DCLK_RATE_POS] ? DMIC_HALF_HI : DMIC_HALF_LO;
   assign half_tick = (dcnt_q >= half - 6'h01);
   assign dmic_clock_out = dclk_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dcnt_q <= 6'h00;
      end else if (!ctrl_q[DCLK_EN_POS] || half_tick) begin
         dcnt_q <= 6'h00;
      end else begin
         dcnt_q <= dcnt_q + 6'h01;
      end
   end

   // clock parks low while disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dclk_q <= 1'b0;
      end else if (!ctrl_q[DCLK_EN_POS]) begin
         dclk_q <= 1'b0;
      end else if (half_tick) begin
         dclk_q <= !dclk_q;
      end
   end

   // high phase length, counted so the check needs no long repetition
   logic [5:0] hi_cnt_q;
   logic hi_fast_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt_q <= 6'h00;
      end else if (!dclk_q) begin
         hi_cnt_q <= 6'h00;
      end else begin
         hi_cnt_q <= hi_cnt_q + 6'h01;
      end
   end

   // a phase is only judged when it ran wholly enabled at the fast rate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_fast_q <= 1'b0;
      end else if (!dclk_q) begin
         hi_fast_q <= 1'b1;
      end else if (!ctrl_q[DCLK_EN_POS] || !ctrl_q[DCLK_RATE_POS]) begin
         hi_fast_q <= 1'b0;
      end
   end

   // ****************
   // pdm capture
   // ****************
   logic [1:0] pin_in;
   logic [1:0] s1_q, s2_q, s3_q, pdm_q, bit_q, bv_q;
   assign pin_in = {right_mic_pin_data, left_mic_pin_data};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pdm
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               pdm_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pin_in[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  pdm_q[g] <= s3_q[g];
               end
            end
         end
         // first mic taken before the rising edge, second before the falling
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               bit_q[g] <= 1'b0;
               bv_q[g] <= 1'b0;
            end else begin
               bv_q[g] <= 1'b0;
               if (half_tick && ctrl_q[DCLK_EN_POS] && (dclk_q == 1'(g))) begin
                  if (g == 0 || ctrl_q[RDIG_POS]) begin
                     bit_q[g] <= pdm_q[g];
                     bv_q[g] <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   assign filt_pdm = bit_q;
   assign filt_pdm_valid = bv_q;

   // ****************
   // routing to serial ports
   // ****************
   logic [15:0] d1, d2, base, st_d;
   logic [15:0] vl_q, vr_q, sl_q, sr_q, st_q;
   logic tv_q;

   // dmic mute for the ports and the dac are independent
   assign d1 = ctrl_q[DTX_MUTE_POS] ? 16'h0000 : dmic_first;
   assign d2 = ctrl_q[DTX_MUTE_POS] ? 16'h0000 : dmic_second;
   // left amp off hands the voice port to the right chain
   assign base = ctrl_q[LMIC_EN_POS] ? adc_left : adc_right;
   assign st_d = (ctrl_q[ST_MUTE_POS] || ctrl_q[ST_MUTE2_POS]) ? 16'h0000 : dmic_second;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vl_q <= 16'h0000;
         vr_q <= 16'h0000;
         sl_q <= 16'h0000;
         sr_q <= 16'h0000;
         st_q <= 16'h0000;
      end else if (smp_valid) begin
         if (mode == ATR_MODE_VOICE) begin
            // left-pin dmic is never used here; right-pin dmic duplicated
            vl_q <= ctrl_q[VR_SRC_POS] ? d2 : base;
            vr_q <= ctrl_q[VR_SRC_POS] ? d2 : base;
            sl_q <= 16'h0000;
            sr_q <= 16'h0000;
         end else begin
            vl_q <= 16'h0000;
            vr_q <= 16'h0000;
            sl_q <= ctrl_q[SL_SRC_POS] ? d1 : adc_left;
            sr_q <= ctrl_q[SR_SRC_POS] ? d2 : adc_right;
         end
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tv_q <= 1'b0;
      end else begin
         tv_q <= smp_valid;
      end
   end

   assign tx_valid = tv_q;
   assign voice_left = vl_q;
   assign voice_right = vr_q;
   assign stereo_left = sl_q;
   assign stereo_right = sr_q;
   assign sidetone = st_q;

   // ****************
   // checks
   // ****************
   chk_amp_power_follows: assert property (@(posedge clk) disable iff (!rst_n)
      (left_amp_power == ctrl_q[LMIC_EN_POS]) && (right_amp_power == ctrl_q[RMIC_EN_POS]))
      else $error("amp power differs from enable");
   chk_input_select: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && paddr == ATR_CTRL_OFS |=> right_src_is_line == $past(pwdata[RSEL_POS]))
      else $error("right input select not applied");
   chk_left_select: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && paddr == ATR_CTRL_OFS |=> left_src_is_line == $past(pwdata[LSEL_POS]))
      else $error("left input select not applied");
   chk_voice_left_both: assert property (@(posedge clk) disable iff (!rst_n)
      smp_valid && ctrl_q[VCE_EN_POS] && !ctrl_q[VR_SRC_POS] && ctrl_q[LMIC_EN_POS]
      |=> voice_left == $past(adc_left) && voice_right == $past(adc_left) && tx_valid)
      else $error("voice port not carrying left source");
   chk_stereo_split: assert property (@(posedge clk) disable iff (!rst_n)
      smp_valid && !ctrl_q[VCE_EN_POS] && !ctrl_q[SL_SRC_POS] && !ctrl_q[SR_SRC_POS]
      |=> stereo_left == $past(adc_left) && stereo_right == $past(adc_right))
      else $error("stereo channels crossed");
   chk_pre_gain_top: assert property (@(posedge clk) disable iff (!rst_n)
      gain_q[LPRE_POS +: 2] == 2'b11 |-> left_pre_db == (ctrl_q[LSEL_POS] ? 8'sh1A : 8'sh1C))
      else $error("left pre gain top code wrong");
   chk_vol_linear: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(lvol_q) |-> left_vol_db - $past(left_vol_db) ==
      $signed({2'b00, lvol_q}) - $signed({2'b00, $past(lvol_q)}))
      else $error("volume not one dB per step");
   chk_dmic_vol_zero: assert property (@(posedge clk) disable iff (!rst_n)
      dvol_q == 6'h06 |-> dmic_vol_db == 8'sh00)
      else $error("dmic volume zero point wrong");
   chk_dclk_gated: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl_q[DCLK_EN_POS] |=> !dmic_clock_out [*2])
      else $error("dmic clock runs while disabled");
   chk_dclk_period: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(dmic_clock_out) && hi_fast_q |-> hi_cnt_q == DMIC_HALF_HI)
      else $error("dmic clock high phase wrong");
   chk_voice_priority: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_q[VCE_EN_POS] && ctrl_q[STR_EN_POS] && smp_valid |=> stereo_left == 16'h0000)
      else $error("stereo active while voice set");
   chk_tx_mute: assert property (@(posedge clk) disable iff (!rst_n)
      smp_valid && ctrl_q[DTX_MUTE_POS] && !ctrl_q[VCE_EN_POS] && ctrl_q[SL_SRC_POS]
      |=> stereo_left == 16'h0000)
      else $error("dmic not muted to port");
   chk_sidetone_mute: assert property (@(posedge clk) disable iff (!rst_n)
      smp_valid && ctrl_q[ST_MUTE2_POS] |=> sidetone == 16'h0000)
      else $error("sidetone not muted");
endmodule
`default_nettype wire

//--- hdl/atr_pkg.sv
package atr_pkg;
   // ****************
   // register map
   // ****************
   localparam logic [7:0] ATR_CTRL_OFS = 8'h00;
   localparam logic [7:0] ATR_GAIN_OFS = 8'h04;
   localparam logic [7:0] ATR_VOL_OFS = 8'h08;
   localparam logic [7:0] ATR_STAT_OFS = 8'h0C;
   // ctrl fields
   localparam int LMIC_EN_POS = 0;
   localparam int RMIC_EN_POS = 1;
   localparam int LSEL_POS = 2;
   localparam int RSEL_POS = 3;
   localparam int LMUTE_POS = 4;
   localparam int RMUTE_POS = 5;
   localparam int VCE_EN_POS = 6;
   localparam int STR_EN_POS = 7;
   localparam int RDIG_POS = 8;
   localparam int DCLK_EN_POS = 9;
   localparam int DCLK_RATE_POS = 10;
   localparam int DTX_MUTE_POS = 11;
   localparam int ST_MUTE_POS = 12;
   localparam int ST_MUTE2_POS = 13;
   localparam int VR_SRC_POS = 14;
   localparam int SL_SRC_POS = 15;
   localparam int SR_SRC_POS = 16;
   localparam int CTRL_W = 17;
   // gain fields
   localparam int LPRE_POS = 0;
   localparam int RPRE_POS = 2;
   localparam int CGAIN_POS = 4;
   // volume fields
   localparam int LVOL_POS = 0;
   localparam int RVOL_POS = 8;
   localparam int DVOL_POS = 16;
   localparam int STG_POS = 24;
   // ****************
   // reset values
   // ****************
   localparam logic [CTRL_W-1:0] CTRL_RST = 17'h00000;
   localparam logic [8:0] GAIN_RST = 9'h000;
   localparam logic [5:0] TXVOL_RST = 6'h39;
   localparam logic [5:0] DVOL_RST = 6'h06;
   localparam logic [5:0] STG_RST = 6'h39;
   // ****************
   // gain mapping and timing
   // ****************
   localparam logic signed [7:0] VOL_MIN_DB = 8'shC7;
   localparam logic signed [7:0] DVOL_ZERO_DB_OFS = 8'sh06;
   localparam int CLK_HZ = 100_000_000;
   localparam int DMIC_LO_HZ = 1_000_000;
   localparam int DMIC_HI_HZ = 2_000_000;
   localparam logic [5:0] DMIC_HALF_LO = 6'(CLK_HZ / (2 * DMIC_LO_HZ));
   localparam logic [5:0] DMIC_HALF_HI = 6'(CLK_HZ / (2 * DMIC_HI_HZ));
   typedef enum logic [1:0] {
      ATR_MODE_VOICE = 2'b01,
      ATR_MODE_STEREO = 2'b10
   } atr_mode_type;
endpackage

//--- testbench/atr_dmic_model.sv
`timescale 1ns/10ps
`default_nettype none
module atr_dmic_model (
   // clock from the device
   input wire logic mclk,
   // data pins toward the device
   output logic left_pin,
   output logic right_pin,
   // last bits driven, seen by the bench
   output logic first_bit,
   output logic second_bit
);
   logic [7:0] pat_a;
   logic [7:0] pat_b;
   initial begin
      pat_a = 8'hB5;
      pat_b = 8'h4E;
      left_pin = 1'b0;
      right_pin = 1'b0;
      first_bit = 1'b0;
      second_bit = 1'b0;
   end
   // ****************
   // two pdm mics sharing one clock
   // ****************
   // released pin shows the inverse so a late sample cannot pass by luck
   always @(mclk) begin
      if (mclk) begin
         second_bit <= pat_b[0];
         right_pin <= pat_b[0];
         pat_b <= {pat_b[6:0], pat_b[7] ^ pat_b[3]};
         left_pin <= ~first_bit;
      end else begin
         first_bit <= pat_a[0];
         left_pin <= pat_a[0];
         pat_a <= {pat_a[6:0], pat_a[7] ^ pat_a[2]};
         right_pin <= ~second_bit;
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb_audio_transmit_input_routing.sv
`timescale 1ns/10ps
`default_nettype none
module tb_audio_transmit_input_routing
   import atr_pkg::*;
;
   logic clk, rst_n, psel, penable, pwrite, smp_valid, lpin, rpin, fbit, sbit;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, lpow, rpow, lline, rline, lmute, rmute, rdig, dclk, tx_valid;
   logic signed [7:0] lpre, rpre, lvol, rvol, dvol, stdb;
   logic [4:0] cgain;
   logic [1:0] fpdm, fval;
   logic [15:0] vl, vr, sl, sr, st;
   int error_cnt, cmp_count;
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      smp_valid = 1'b0;
      error_cnt = 0;
      cmp_count = 0;
   end
   always #5 clk = ~clk;
   atr_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .left_amp_power(lpow), .right_amp_power(rpow), .left_src_is_line(lline),
      .right_src_is_line(rline), .left_amp_mute(lmute), .right_amp_mute(rmute),
      .left_pre_db(lpre), .right_pre_db(rpre), .conv_gain(cgain), .left_vol_db(lvol),
      .right_vol_db(rvol), .dmic_vol_db(dvol), .sidetone_db(stdb), .right_pin_digital(rdig),
      .dmic_clock_out(dclk), .left_mic_pin_data(lpin), .right_mic_pin_data(rpin),
      .filt_pdm(fpdm), .filt_pdm_valid(fval), .smp_valid(smp_valid), .adc_left(16'h1111),
      .adc_right(16'h2222), .dmic_first(16'h3333), .dmic_second(16'h4444),
      .tx_valid(tx_valid), .voice_left(vl), .voice_right(vr), .stereo_left(sl),
      .stereo_right(sr), .sidetone(st));
   atr_dmic_model mic_u (.mclk(dclk), .left_pin(lpin), .right_pin(rpin), .first_bit(fbit),
      .second_bit(sbit));
   // ****************
   // shared tasks
   // ****************
   task automatic complete_run;
      if (error_cnt == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      rdchk(ATR_CTRL_OFS, 32'h0);
      rdchk(ATR_VOL_OFS, 32'h39063939);
      check(lvol, 32'h0);
      check(dvol, 32'h0);
      apb(1'b1, ATR_STAT_OFS, 32'hFFFFFFFF);
      rdchk(ATR_STAT_OFS, 32'h2);
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      check(err, 32'h1);
      rdchk(8'h10, 32'h0);
      check(err, 32'h1);
   endtask
   task automatic t_ctrl;
      logic [31:0] cv[2] = '{32'h125, 32'h0DA};
      foreach (cv[i]) begin
         apb(1'b1, ATR_CTRL_OFS, cv[i]);
         @(negedge clk);
         check({lpow, rpow}, {cv[i][0], cv[i][1]});
         check({lline, rline}, {cv[i][2], cv[i][3]});
         check({lmute, rmute}, {cv[i][4], cv[i][5]});
         check(rdig, cv[i][8]);
         rdchk(ATR_CTRL_OFS, cv[i]);
      end
   endtask
   task automatic t_gain;
      int mic[4] = '{0, 12, 20, 28};
      int lin[4] = '{0, 8, 18, 26};
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, ATR_CTRL_OFS, (s == 1) ? 32'hC : 32'h0);
            apb(1'b1, ATR_GAIN_OFS, 32'(c | ((3 - c) << 2) | ((c * 7) << 4)));
            @(negedge clk);
            check(lpre, (s == 1) ? lin[c] : mic[c]);
            check(rpre, (s == 1) ? lin[3 - c] : mic[3 - c]);
            check(cgain, c * 7);
         end
      end
   endtask
   task automatic t_vol;
      int codes[5] = '{0, 1, 57, 62, 63};
      int c;
      foreach (codes[i]) begin
         c = codes[i];
         apb(1'b1, ATR_VOL_OFS, 32'(c | ((63 - c) << 8) | (c << 16) | (c << 24)));
         @(negedge clk);
         check(lvol, 32'(c - 57));
         check(rvol, 32'(6 - c));
         check(dvol, 32'(6 - c));
         check(stdb, 32'(c - 57));
      end
   endtask
   task automatic t_route(input logic [31:0] cv, input logic [15:0] evl, input logic [15:0] esl,
                          input logic [15:0] esr, input logic [15:0] est, input logic [1:0] em);
      apb(1'b1, ATR_CTRL_OFS, cv);
      @(posedge clk);
      smp_valid <= 1'b1;
      @(posedge clk);
      smp_valid <= 1'b0;
      @(negedge clk);
      check(tx_valid, 32'h1);
      check({vl, vr}, {evl, evl});
      check({sl, sr}, {esl, esr});
      check(st, est);
      @(negedge clk);
      check(tx_valid, 32'h0);
      rdchk(ATR_STAT_OFS, 32'(em));
   endtask
   task automatic halfp(input int exp);
      int n;
      int h;
      logic last;
      n = 0;
      h = 0;
      @(negedge clk);
      last = dclk;
      while (dclk === last && n < 200) begin
         @(negedge clk);
         n++;
      end
      last = dclk;
      while (dclk === last && h < 200) begin
         @(negedge clk);
         h++;
      end
      if (n >= 200 || h >= 200) begin
         error_cnt++;
         complete_run();
      end
      check(h, exp);
   endtask
   task automatic capt(input logic two);
      int k0;
      int k1;
      k0 = 0;
      k1 = 0;
      repeat (400) begin
         @(negedge clk);
         if (fval[0] === 1'b1) begin
            k0++;
            check(fpdm[0], fbit);
         end
         if (fval[1] === 1'b1) begin
            k1++;
            check(fpdm[1], sbit);
         end
      end
      check(k0 > 0, 32'h1);
      check(k1 > 0, two);
   endtask
   task automatic t_dmic;
      int bad;
      bad = 0;
      apb(1'b1, ATR_CTRL_OFS, 32'h200);
      halfp(DMIC_HALF_LO);
      capt(1'b0);
      apb(1'b1, ATR_CTRL_OFS, 32'h0);
      repeat (3) @(negedge clk);
      repeat (300) begin
         @(negedge clk);
         if (dclk !== 1'b0 || fval !== 2'b00)
            bad++;
      end
      check(bad, 0);
      // idle gap first, so the rate change never yields a short phase
      apb(1'b1, ATR_CTRL_OFS, 32'h700);
      halfp(DMIC_HALF_HI);
      capt(1'b1);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ctrl();
      t_gain();
      t_vol();
      t_route(32'h00041, 16'h1111, 16'h0, 16'h0, 16'h4444, 2'b01);
      t_route(32'h000C0, 16'h2222, 16'h0, 16'h0, 16'h4444, 2'b01);
      t_route(32'h04041, 16'h4444, 16'h0, 16'h0, 16'h4444, 2'b01);
      t_route(32'h04841, 16'h0, 16'h0, 16'h0, 16'h4444, 2'b01);
      t_route(32'h01080, 16'h0, 16'h1111, 16'h2222, 16'h0, 2'b10);
      t_route(32'h1A080, 16'h0, 16'h3333, 16'h4444, 16'h0, 2'b10);
      t_route(32'h18880, 16'h0, 16'h0, 16'h0, 16'h4444, 2'b10);
      t_dmic();
      complete_run();
   end
endmodule
`default_nettype wire
